// ### rtl/rxe_exec.sv
// Contract
// - Load halfword reads storage halfword into selected general register.
// - Nonzero index nibble halts with error code 6; code checks it only for load, add, subtract halfword and branch and link.
// - Add halfword adds storage halfword into selected register.
// - Halfword operand of add and subtract lies at even address.
// - Halfword arithmetic adds all sixteen bits in two's complement.
// - Overflow when sign carry differs from top numeric carry; sign kept.
// - Add or subtract overflow halts with error code 8.
// - Add sets code 00 zero, 01 negative, 10 positive.
// - Subtract adds two's complement of storage halfword to register.
// - Subtract sets code 00 zero, 01 negative, 10 positive.
// - Most negative minus itself gives zero with no overflow.
// - Branch and link saves low status half, then loads branch address.
// - I/O interrupt stores status word at 144, fetches new from 148.
// - Status word is internal one-word register, not program addressable.
// - Status load takes whole 32-bit word from any address.
// - Status load sets condition code from the loaded word.
// - Reset clears code, ASCII bit, channel mask; keeps instruction address.
// - Test under mask sets code from AND, modifies nothing.
// - Move immediate writes immediate byte to storage.
// - AND immediate writes back result, code 00 zero else 01.
// - OR immediate writes back result, code 00 zero else 01.
// - Branch and link and status load keep code unless word supplies it.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module rxe_exec (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  // Instruction issue
  input  wire rxe_pkg::rxe_instr_t  instr_in,
  input  wire logic                 io_interrupt_in,
  output logic                      busy_out,
  output logic                      done_out,
  // Main storage, read data one cycle after request
  output rxe_pkg::rxe_mem_req_t     mem_req_out,
  input  wire logic [7:0]           mem_rdata_in,
  // General registers
  output logic [3:0]                gr_rsel_out,
  input  wire logic [15:0]          gr_rdata_in,
  output rxe_pkg::rxe_gr_wr_t       gr_wr_out,
  // Status
  output logic [31:0]               psw_out,
  output logic [1:0]                condition_code_out,
  output logic [3:0]                error_indicator_reg_out,
  output logic                      stopped_out
);
  import rxe_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_EXEC, ST_PSW_STORE, ST_PSW_FETCH, ST_STOP
  } rxe_state_t;

  rxe_state_t   state_ff, nxt_state;
  logic [31:0]  psw_ff, nxt_psw;
  logic [3:0]   err_ff, nxt_err;
  logic [2:0]   cnt_ff, nxt_cnt;
  logic         rdv_ff;
  logic [31:0]  buf_ff, nxt_buf;
  logic [7:0]   op_ff;
  logic [3:0]   r1_ff;
  logic [15:0]  addr_ff;
  logic [7:0]   imm_ff;
  rxe_mem_req_t req_ff, nxt_req;
  rxe_gr_wr_t   grw_ff, nxt_grw;
  logic         done_ff, nxt_done;

  function automatic logic is_halfword_arith(input logic [7:0] op);
    return (op == ADD_HALFWORD_OP) || (op == SUBTRACT_HALFWORD_OP);
  endfunction : is_halfword_arith

  function automatic logic is_rx(input logic [7:0] op);
    return (op == LOAD_HALFWORD_OP) || is_halfword_arith(op) || (op == BRANCH_LINK_OP);
  endfunction : is_rx

  function automatic logic is_si(input logic [7:0] op);
    return (op == TEST_MASK_OP) || (op == MOVE_IMMEDIATE_OP) ||
           (op == AND_IMMEDIATE_OP) || (op == OR_IMMEDIATE_OP);
  endfunction : is_si

  // ****************************************
  // Datapath helpers
  // ****************************************
  logic [15:0] alu_sum;
  logic        alu_ovf;
  logic [1:0]  alu_cc;
  logic [7:0]  byte_res;
  logic [1:0]  byte_cc;
  logic        byte_wb;
  logic [15:0] hw_operand;
  logic        spec_bad;
  logic        align_bad;
  logic        accept;

  assign hw_operand = buf_ff[15:0];
  assign spec_bad   = is_rx(instr_in.opcode) && (instr_in.index_field != 4'h0);
  assign align_bad  = is_halfword_arith(instr_in.opcode) && instr_in.operand_addr[0];
  assign accept     = (state_ff == ST_IDLE) && instr_in.valid;

  rxe_hw_alu u_alu (
    .reg_op_in    (gr_rdata_in),
    .mem_op_in    (hw_operand),
    .subtract_in  (op_ff == SUBTRACT_HALFWORD_OP),
    .sum_out      (alu_sum),
    .overflow_out (alu_ovf),
    .cc_out       (alu_cc)
  );

  rxe_byte_logic u_byte (
    .opcode_in      (op_ff),
    .mem_byte_in    (buf_ff[7:0]),
    .imm_in         (imm_ff),
    .result_out     (byte_res),
    .cc_out         (byte_cc),
    .write_back_out (byte_wb)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_psw   = psw_ff;
    nxt_err   = err_ff;
    nxt_cnt   = cnt_ff;
    nxt_buf   = buf_ff;
    nxt_req   = '0;
    nxt_grw   = '0;
    nxt_done  = 1'b0;
    if (rdv_ff) begin
      nxt_buf = {buf_ff[23:0], mem_rdata_in};
    end
    unique case (state_ff)
      ST_IDLE: begin
        nxt_cnt = 3'h0;
        if (io_interrupt_in) begin
          nxt_state = ST_PSW_STORE;
        end else if (instr_in.valid) begin
          if (spec_bad || align_bad) begin
            nxt_err   = ERR_SPECIFICATION;
            nxt_state = ST_STOP;
          end else if (instr_in.opcode == BRANCH_LINK_OP) begin
            nxt_grw.we    = 1'b1;
            nxt_grw.sel   = instr_in.first_register_field;
            nxt_grw.wdata = psw_ff[15:0];
            nxt_psw[15:0] = instr_in.operand_addr;
            nxt_done      = 1'b1;
          end else if (is_rx(instr_in.opcode) || is_si(instr_in.opcode) ||
                       (instr_in.opcode == LOAD_STATUS_WORD_OP)) begin
            nxt_state = ST_READ;
          end else begin
            nxt_done = 1'b1;
          end
        end
      end
      ST_READ: begin
        // Issue byte reads, MSB first
        if (cnt_ff < ((op_ff == LOAD_STATUS_WORD_OP) ? 3'(PSW_BYTES) :
                      is_si(op_ff) ? 3'h1 : 3'(HW_BYTES))) begin
          nxt_req.rd   = 1'b1;
          nxt_req.addr = addr_ff + {13'h0000, cnt_ff};
          nxt_cnt      = cnt_ff + 3'h1;
        end else if (!rdv_ff && !req_ff.rd) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_state = ST_IDLE;
        nxt_done  = 1'b1;
        if (op_ff == LOAD_STATUS_WORD_OP) begin
          nxt_psw = buf_ff;
        end else if (op_ff == LOAD_HALFWORD_OP) begin
          nxt_grw = '{we: 1'b1, sel: r1_ff, wdata: hw_operand};
        end else if (is_halfword_arith(op_ff)) begin
          nxt_grw = '{we: 1'b1, sel: r1_ff, wdata: alu_sum};
          nxt_psw[PSW_CC_LSB +: 2] = alu_cc;
          if (alu_ovf) begin
            nxt_err   = ERR_OVERFLOW;
            nxt_state = ST_STOP;
            nxt_done  = 1'b0;
          end
        end else begin
          nxt_psw[PSW_CC_LSB +: 2] = byte_cc;
          nxt_req = '{rd: 1'b0, wr: byte_wb, addr: addr_ff, wdata: byte_res};
        end
      end
      ST_PSW_STORE: begin
        // Old status word out, MSB first
        nxt_req.wr    = 1'b1;
        nxt_req.addr  = IO_OLD_PSW_ADDR + {13'h0000, cnt_ff};
        nxt_req.wdata = psw_ff[8'(31 - 8 * int'(cnt_ff)) -: 8];
        nxt_cnt       = cnt_ff + 3'h1;
        if (cnt_ff == 3'(PSW_BYTES - 1)) begin
          nxt_cnt   = 3'h0;
          nxt_state = ST_PSW_FETCH;
        end
      end
      ST_PSW_FETCH: begin
        if (cnt_ff < 3'(PSW_BYTES)) begin
          nxt_req.rd   = 1'b1;
          nxt_req.addr = IO_NEW_PSW_ADDR + {13'h0000, cnt_ff};
          nxt_cnt      = cnt_ff + 3'h1;
        end else if (!rdv_ff && !req_ff.rd) begin
          nxt_psw   = buf_ff;
          nxt_state = ST_IDLE;
        end
      end
      ST_STOP: begin
        nxt_state = ST_STOP;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_ff <= ST_IDLE;
      err_ff   <= ERR_NONE;
      cnt_ff   <= 3'h0;
      rdv_ff   <= 1'b0;
      req_ff   <= '0;
      grw_ff   <= '0;
      done_ff  <= 1'b0;
      // Instruction address survives reset
      psw_ff[PSW_MASK_BIT]      <= 1'b0;
      psw_ff[PSW_ASCII_BIT]     <= 1'b0;
      psw_ff[PSW_CC_LSB +: 2]   <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      err_ff   <= nxt_err;
      cnt_ff   <= nxt_cnt;
      rdv_ff   <= req_ff.rd;
      req_ff   <= nxt_req;
      grw_ff   <= nxt_grw;
      done_ff  <= nxt_done;
      psw_ff   <= nxt_psw;
    end
  end

  // Fields not touched by reset
  always_ff @(posedge clk_in) begin
    buf_ff        <= nxt_buf;
    if (accept) begin
      op_ff   <= instr_in.opcode;
      r1_ff   <= instr_in.first_register_field;
      addr_ff <= instr_in.operand_addr;
      imm_ff  <= instr_in.immediate_byte_field;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busy_out                = (state_ff != ST_IDLE);
  assign done_out                = done_ff;
  assign mem_req_out             = req_ff;
  assign gr_rsel_out             = r1_ff;
  assign gr_wr_out               = grw_ff;
  assign psw_out                 = psw_ff;
  assign condition_code_out      = psw_ff[PSW_CC_LSB +: 2];
  assign error_indicator_reg_out = err_ff;
  assign stopped_out             = (state_ff == ST_STOP);

  // ****************************************
  // Checks
  // ****************************************
  a_spec_stop: assert property (@(posedge clk_in) disable iff (reset_in)
    (accept && !io_interrupt_in && spec_bad) |=> (stopped_out && err_ff == ERR_SPECIFICATION))
    else $error("specification stop missing");
  a_ovf_stop: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && is_halfword_arith(op_ff) && alu_ovf) |=> (err_ff == ERR_OVERFLOW))
    else $error("overflow code missing");
  a_add_cc: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && is_halfword_arith(op_ff) && alu_sum == 16'h0000)
      |=> condition_code_out == CC_ZERO)
    else $error("zero sum code wrong");
  a_neg_cc: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && is_halfword_arith(op_ff) && alu_sum[15] && !alu_ovf)
      |=> condition_code_out == CC_LOW)
    else $error("negative code wrong");
  a_link_write: assert property (@(posedge clk_in) disable iff (reset_in)
    (accept && !io_interrupt_in && !spec_bad && instr_in.opcode == BRANCH_LINK_OP)
      |=> (gr_wr_out.we && gr_wr_out.wdata == $past(psw_ff[15:0])
           && psw_ff[15:0] == $past(instr_in.operand_addr)))
    else $error("link write wrong");
  a_link_cc: assert property (@(posedge clk_in) disable iff (reset_in)
    (accept && !io_interrupt_in && instr_in.opcode == BRANCH_LINK_OP) |=> $stable(condition_code_out))
    else $error("link changed code");
  a_psw_load: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && op_ff == LOAD_STATUS_WORD_OP) |=> psw_out == $past(buf_ff))
    else $error("status load wrong");
  a_tm_nowrite: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && op_ff == TEST_MASK_OP) |=> !mem_req_out.wr)
    else $error("test under mask wrote");
  a_irq_store: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_IDLE && io_interrupt_in)
      |=> ##1 (mem_req_out.wr && mem_req_out.addr == IO_OLD_PSW_ADDR))
    else $error("interrupt store wrong");
  a_load_write: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && op_ff == LOAD_HALFWORD_OP)
      |=> (gr_wr_out.we && gr_wr_out.sel == $past(r1_ff)
           && gr_wr_out.wdata == $past(hw_operand)))
    else $error("halfword load write wrong");
  a_align_stop: assert property (@(posedge clk_in) disable iff (reset_in)
    (accept && !io_interrupt_in && align_bad) |=> (stopped_out && err_ff == ERR_SPECIFICATION))
    else $error("odd halfword address accepted");
  a_sum_write: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && is_halfword_arith(op_ff))
      |=> (gr_wr_out.we && gr_wr_out.wdata == $past(alu_sum)))
    else $error("halfword sum not written");
  a_pos_cc: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && is_halfword_arith(op_ff) && alu_sum != 16'h0000 && !alu_sum[15])
      |=> condition_code_out == CC_HIGH)
    else $error("positive code wrong");
  a_min_neg: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && op_ff == SUBTRACT_HALFWORD_OP && gr_rdata_in == 16'h8000
     && hw_operand == 16'h8000) |=> (!stopped_out && condition_code_out == CC_ZERO))
    else $error("most negative difference wrong");
  a_status_cc: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && op_ff == LOAD_STATUS_WORD_OP)
      |=> condition_code_out == $past(buf_ff[PSW_CC_LSB +: 2]))
    else $error("status load code wrong");
  a_reset_ctrl: assert property (@(posedge clk_in)
    reset_in |=> (condition_code_out == CC_ZERO && !psw_out[PSW_ASCII_BIT]
                  && !psw_out[PSW_MASK_BIT]))
    else $error("reset left control bits set");
  a_move_data: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && op_ff == MOVE_IMMEDIATE_OP)
      |=> (mem_req_out.wr && mem_req_out.wdata == $past(imm_ff)))
    else $error("move immediate data wrong");
  a_or_write: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && op_ff == OR_IMMEDIATE_OP)
      |=> (mem_req_out.wr && mem_req_out.addr == $past(addr_ff)
           && mem_req_out.wdata == ($past(buf_ff[7:0]) | $past(imm_ff))))
    else $error("or immediate write wrong");
  a_and_cc: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_ff == ST_EXEC && op_ff == AND_IMMEDIATE_OP && (buf_ff[7:0] & imm_ff) == 8'h00)
      |=> condition_code_out == CC_ZERO)
    else $error("and immediate code wrong");

endmodule : rxe_exec

// ### rtl/rxe_pkg.sv
package rxe_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] LOAD_HALFWORD_OP     = 8'h48;
  localparam logic [7:0] ADD_HALFWORD_OP      = 8'h4A;
  localparam logic [7:0] SUBTRACT_HALFWORD_OP = 8'h4B;
  localparam logic [7:0] BRANCH_LINK_OP       = 8'h4D;
  localparam logic [7:0] LOAD_STATUS_WORD_OP  = 8'h81;
  localparam logic [7:0] TEST_MASK_OP         = 8'h91;
  localparam logic [7:0] MOVE_IMMEDIATE_OP    = 8'h92;
  localparam logic [7:0] AND_IMMEDIATE_OP     = 8'h94;
  localparam logic [7:0] OR_IMMEDIATE_OP      = 8'h96;

  // ****************************************
  // Error codes, fixed addresses, reset values
  // ****************************************
  localparam logic [3:0]  ERR_NONE          = 4'h0;
  localparam logic [3:0]  ERR_SPECIFICATION = 4'h6;
  localparam logic [3:0]  ERR_OVERFLOW      = 4'h8;
  localparam logic [15:0] IO_OLD_PSW_ADDR   = 16'h0090;
  localparam logic [15:0] IO_NEW_PSW_ADDR   = 16'h0094;
  localparam logic [1:0]  CC_ZERO           = 2'h0;
  localparam logic [1:0]  CC_LOW            = 2'h1;
  localparam logic [1:0]  CC_HIGH           = 2'h2;
  localparam logic [7:0]  PSW_CTRL_RESET    = 8'h00;
  localparam int          PSW_BYTES         = 4;
  localparam int          HW_BYTES          = 2;

  // ****************************************
  // Field positions of the status word
  // ****************************************
  localparam int PSW_CC_LSB    = 20;
  localparam int PSW_ASCII_BIT = 22;
  localparam int PSW_MASK_BIT  = 23;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [3:0]  first_register_field;
    logic [3:0]  index_field;
    logic [15:0] operand_addr;
    logic [7:0]  immediate_byte_field;
  } rxe_instr_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } rxe_mem_req_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  sel;
    logic [15:0] wdata;
  } rxe_gr_wr_t;

endpackage : rxe_pkg

// ### rtl/rxe_hw_alu.sv
`timescale 1ns/1ps
module rxe_hw_alu (
  // Operands
  input  wire logic [15:0] reg_op_in,
  input  wire logic [15:0] mem_op_in,
  input  wire logic        subtract_in,
  // Result
  output logic [15:0]      sum_out,
  output logic             overflow_out,
  output logic [1:0]       cc_out
);
  import rxe_pkg::*;

  logic [15:0] addend;
  logic [14:0] low_sum;
  logic        carry_num;
  logic        carry_sign;
  logic        sign_bit;

  // Two's complement of the storage operand for subtract
  assign addend = subtract_in ? ~mem_op_in : mem_op_in;
  // All sixteen positions take part
  assign {carry_num, low_sum} = {1'b0, reg_op_in[14:0]} + {1'b0, addend[14:0]}
                                + {15'h0000, subtract_in};
  assign {carry_sign, sign_bit} = {1'b0, reg_op_in[15]} + {1'b0, addend[15]}
                                  + {1'b0, carry_num};
  assign sum_out      = {sign_bit, low_sum};
  assign overflow_out = carry_sign ^ carry_num;
  assign cc_out       = (sum_out == 16'h0000) ? CC_ZERO :
                        sum_out[15] ? CC_LOW : CC_HIGH;

endmodule : rxe_hw_alu

// ### rtl/rxe_byte_logic.sv
`timescale 1ns/1ps
module rxe_byte_logic (
  // Operands
  input  wire logic [7:0] opcode_in,
  input  wire logic [7:0] mem_byte_in,
  input  wire logic [7:0] imm_in,
  // Result
  output logic [7:0]      result_out,
  output logic [1:0]      cc_out,
  output logic            write_back_out
);
  import rxe_pkg::*;

  logic [7:0] and_res;
  logic [7:0] or_res;

  assign and_res = mem_byte_in & imm_in;
  assign or_res  = mem_byte_in | imm_in;
  assign result_out = (opcode_in == OR_IMMEDIATE_OP)    ? or_res :
                      (opcode_in == MOVE_IMMEDIATE_OP)  ? imm_in : and_res;
  assign cc_out = (result_out == 8'h00) ? CC_ZERO : CC_LOW;
  // Test under mask leaves storage untouched
  assign write_back_out = (opcode_in != TEST_MASK_OP);

endmodule : rxe_byte_logic

// ### tb/rxe_storage_model.sv
`timescale 1ns/1ps
module rxe_storage_model (
  // Clock
  input  wire logic                  clk_in,
  // Storage port
  input  wire rxe_pkg::rxe_mem_req_t mem_req_in,
  output logic [7:0]                 rdata_out
);
  import rxe_pkg::*;

  // ****************************************
  // Byte array, big-endian by address
  // ****************************************
  logic [7:0] mem [0:65535];

  initial begin
    rdata_out = 8'h00;
  end

  // Read data stand only in the cycle after the strobe, then turn over
  always @(posedge clk_in) begin
    if (mem_req_in.rd) begin
      rdata_out <= mem[mem_req_in.addr];
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (mem_req_in.wr) begin
      mem[mem_req_in.addr] <= mem_req_in.wdata;
    end
  end
endmodule : rxe_storage_model

// ### tb/rxe_exec_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end
module rxe_exec_tb_top;
  import rxe_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic         clk_in;
  logic         reset_in;
  rxe_instr_t   instr;
  logic         io_irq;
  logic         busy;
  logic         done_out;
  rxe_mem_req_t mem_req;
  logic [7:0]   mem_rdata;
  logic [3:0]   gr_rsel;
  logic [15:0]  gr_rdata;
  rxe_gr_wr_t   gr_wr;
  logic [31:0]  program_status_word;
  logic [1:0]   cc;
  logic [3:0]   err;
  logic         stopped_out;
  logic [15:0]  gr [0:15];
  int           n_errors;
  int           n_checks;

  rxe_exec i_rxe_exec (
    .clk_in(clk_in), .reset_in(reset_in), .instr_in(instr), .io_interrupt_in(io_irq),
    .busy_out(busy), .done_out(done_out), .mem_req_out(mem_req), .mem_rdata_in(mem_rdata),
    .gr_rsel_out(gr_rsel), .gr_rdata_in(gr_rdata), .gr_wr_out(gr_wr), .psw_out(program_status_word),
    .condition_code_out(cc), .error_indicator_reg_out(err), .stopped_out(stopped_out)
  );

  rxe_storage_model i_rxe_storage_model (
    .clk_in(clk_in), .mem_req_in(mem_req), .rdata_out(mem_rdata)
  );

  // General register file on the far side
  assign gr_rdata = gr[gr_rsel];
  always @(posedge clk_in) begin
    if (gr_wr.we) begin
      gr[gr_wr.sel] <= gr_wr.wdata;
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset;
    reset_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
  endtask : do_reset

  task automatic wait_end(input logic idle_only);
    int i;
    for (i = 0; i < 40; i++) begin
      #1;
      if (idle_only && busy === 1'b0) break;
      if (!idle_only && (done_out === 1'b1 || stopped_out === 1'b1)) break;
      @(posedge clk_in);
    end
    if (i == 40) begin
      n_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, 8'h00, 8'h01);
      tally_and_finish();
    end
  endtask : wait_end

  task automatic run(input logic [7:0] op, input logic [3:0] r1, input logic [3:0] idx,
                     input logic [15:0] addr, input logic [7:0] imm);
    @(posedge clk_in);
    instr <= '{1'b1, op, r1, idx, addr, imm};
    @(posedge clk_in);
    instr.valid <= 1'b0;
    wait_end(1'b0);
    // One more edge so register and storage writes have landed
    @(posedge clk_in);
    #1;
  endtask : run

  task automatic set_hw(input logic [15:0] addr, input logic [15:0] val);
    i_rxe_storage_model.mem[addr]         = val[15:8];
    i_rxe_storage_model.mem[addr + 16'h1] = val[7:0];
  endtask : set_hw

  task automatic hw_case(input logic [7:0] op, input logic [15:0] a, input logic [15:0] b,
                         input logic [15:0] exp, input logic [1:0] exp_cc);
    gr[4] = a;
    set_hw(16'h0200, b);
    run(op, 4'h4, 4'h0, 16'h0200, 8'h00);
    `CHK(gr[4], exp)
    `CHK(cc, exp_cc)
    `CHK(stopped_out, 1'b0)
  endtask : hw_case

  task automatic stop_case(input logic [7:0] op, input logic [3:0] idx,
                           input logic [15:0] addr, input logic [3:0] exp_err);
    gr[4] = 16'h7FFF;
    set_hw(16'h0200, 16'h0001);
    run(op, 4'h4, idx, addr, 8'h00);
    `CHK(stopped_out, 1'b1)
    `CHK(err, exp_err)
    do_reset();
  endtask : stop_case

  task automatic byte_case(input logic [7:0] op, input logic [7:0] m, input logic [7:0] imm,
                           input logic [7:0] exp_m, input logic [1:0] exp_cc);
    i_rxe_storage_model.mem[16'h0310] = m;
    run(op, 4'h0, 4'h0, 16'h0310, imm);
    `CHK(i_rxe_storage_model.mem[16'h0310], exp_m)
    `CHK(cc, exp_cc)
  endtask : byte_case

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n_errors = 0;
    n_checks = 0;
    reset_in = 1'b1;
    instr    = '0;
    io_irq   = 1'b0;
    for (int k = 0; k < 16; k++) gr[k] = 16'h0000;
    do_reset();
    `CHK(err, ERR_NONE)
    set_hw(16'h0100, 16'h1234);
    run(LOAD_HALFWORD_OP, 4'h3, 4'h0, 16'h0100, 8'h00);
    `CHK(gr[3], 16'h1234)
    hw_case(ADD_HALFWORD_OP, 16'h0001, 16'hFFFF, 16'h0000, 2'h0);
    hw_case(ADD_HALFWORD_OP, 16'h0005, 16'hFFF6, 16'hFFFB, 2'h1);
    hw_case(ADD_HALFWORD_OP, 16'h0003, 16'h0004, 16'h0007, 2'h2);
    hw_case(SUBTRACT_HALFWORD_OP, 16'h8000, 16'h8000, 16'h0000, 2'h0);
    hw_case(SUBTRACT_HALFWORD_OP, 16'h0005, 16'h0007, 16'hFFFE, 2'h1);
    hw_case(SUBTRACT_HALFWORD_OP, 16'h0007, 16'h0005, 16'h0002, 2'h2);
    stop_case(ADD_HALFWORD_OP, 4'h0, 16'h0200, ERR_OVERFLOW);
    stop_case(LOAD_HALFWORD_OP, 4'h1, 16'h0200, ERR_SPECIFICATION);
    stop_case(ADD_HALFWORD_OP, 4'h0, 16'h0201, ERR_SPECIFICATION);
    `CHK(err, ERR_NONE)
    byte_case(TEST_MASK_OP, 8'hAA, 8'h6D, 8'hAA, 2'h1);
    byte_case(TEST_MASK_OP, 8'hAA, 8'h00, 8'hAA, 2'h0);
    byte_case(MOVE_IMMEDIATE_OP, 8'hAA, 8'h5C, 8'h5C, 2'h1);
    byte_case(AND_IMMEDIATE_OP, 8'hAA, 8'h6D, 8'h28, 2'h1);
    byte_case(AND_IMMEDIATE_OP, 8'hAA, 8'h55, 8'h00, 2'h0);
    byte_case(OR_IMMEDIATE_OP, 8'h00, 8'h00, 8'h00, 2'h0);
    byte_case(OR_IMMEDIATE_OP, 8'hAA, 8'h01, 8'hAB, 2'h1);
    // Status word load from an odd address
    set_hw(16'h0301, 16'hC2E5);
    set_hw(16'h0303, 16'hABCD);
    run(LOAD_STATUS_WORD_OP, 4'h0, 4'h0, 16'h0301, 8'h00);
    `CHK(program_status_word, 32'hC2E5ABCD)
    `CHK(cc, 2'h2)
    run(BRANCH_LINK_OP, 4'h5, 4'h0, 16'h0444, 8'h00);
    `CHK(gr[5], 16'hABCD)
    `CHK(program_status_word, 32'hC2E50444)
    `CHK(cc, 2'h2)
    do_reset();
    `CHK(program_status_word, 32'hC2050444)
    // I/O interrupt swaps the status word
    set_hw(16'h0094, 16'h0031);
    set_hw(16'h0096, 16'h2345);
    @(posedge clk_in);
    io_irq <= 1'b1;
    @(posedge clk_in);
    io_irq <= 1'b0;
    wait_end(1'b1);
    `CHK({i_rxe_storage_model.mem[144], i_rxe_storage_model.mem[145]}, 16'hC205)
    `CHK({i_rxe_storage_model.mem[146], i_rxe_storage_model.mem[147]}, 16'h0444)
    `CHK(program_status_word, 32'h00312345)
    `CHK(cc, 2'h3)
    tally_and_finish();
  end
endmodule : rxe_exec_tb_top
